// File: verilog/isam_map.vh
// register offsets, field positions and reset values of the status and address mask block
`ifndef ISAM_MAP_VH
`define ISAM_MAP_VH
`define ISAM_OFF_STAT     12'h000
`define ISAM_OFF_MASK     12'h004
`define ISAM_OFF_CTRL     12'h008
`define ISAM_OFF_ADDR     12'h00c
`define ISAM_OFF_TXD      12'h010
`define ISAM_OFF_RXD      12'h014
`define ISAM_OFF_IRQ_STAT 12'h018
`define ISAM_OFF_IRQ_EN   12'h01c
`define ISAM_OFF_IRQ_CLR  12'h020
`define ISAM_ADDR_W       12
`define ISAM_B_ACK        15
`define ISAM_B_TRS        14
`define ISAM_B_COLL       10
`define ISAM_B_GC         9
`define ISAM_B_A10        8
`define ISAM_B_WCOL       7
`define ISAM_B_OV         6
`define ISAM_B_DA         5
`define ISAM_B_P          4
`define ISAM_B_S          3
`define ISAM_B_RW         2
`define ISAM_B_RXFULL     1
`define ISAM_B_TXFULL     0
`define ISAM_MASK_W       10
`define ISAM_MASK7        10'h07f
`define ISAM_MASK10       10'h3ff
`define ISAM_GC_ADDR      10'h000
`define ISAM_CTRL_TEN     0
`define ISAM_CTRL_GCEN    1
`define ISAM_IRQ_W        4
`define ISAM_IRQ_RX       0
`define ISAM_IRQ_COLL     1
`define ISAM_IRQ_WCOL     2
`define ISAM_IRQ_OV       3
`define ISAM_ZERO16       16'h0000
`define ISAM_ZERO32       32'h00000000
`endif

// File: verilog/isam_addr_match.v
// masked slave address comparator, seven or ten bit
`timescale 1ns/1ps
module isam_addr_match (
	input  wire [9:0] own_addr_i,  // programmed slave address
	input  wire [9:0] rx_addr_i,   // incoming address bits
	input  wire [9:0] mask_i,      // set bit means do not care
	input  wire       ten_bit_i,   // address width select
	output wire       match_o      // masked compare result
);
`include "isam_map.vh"
	// upper mask and address bits ignored for 7-bit width
	wire [9:0] width_sel = ten_bit_i ? `ISAM_MASK10 : `ISAM_MASK7;
	wire [9:0] care      = width_sel & ~mask_i;
	assign match_o = ((own_addr_i ^ rx_addr_i) & care) == `ISAM_GC_ADDR;
endmodule // isam_addr_match

// File: verilog/isam_top.v
// status flags, address mask and apb register file of the serial bus block
`timescale 1ns/1ps
module isam_top (
	input  wire        CLK_I,            // 250 MHz module clock
	input  wire        RST_B_I,          // async reset, active low
	input  wire        PSEL_I,           // apb select
	input  wire        PENABLE_I,        // apb access phase
	input  wire        PWRITE_I,         // apb direction
	input  wire [11:0] PADDR_I,          // apb byte address
	input  wire [31:0] PWDATA_I,         // apb write data
	output reg  [31:0] PRDATA_O,         // apb read data
	output reg         PREADY_O,         // apb ready
	output reg         PSLVERR_O,        // apb unmapped address
	input  wire        ACK_SLOT_END_I,   // pulse, end of slave ack slot
	input  wire        ACK_NACK_I,       // sampled ack level, 1 = nack
	input  wire        MTX_START_I,      // pulse, master byte begins
	input  wire        COLLISION_I,      // pulse, bus collision seen
	input  wire        START_DET_I,      // pulse, start or repeated start
	input  wire        STOP_DET_I,       // pulse, stop seen
	input  wire        ADDR_BYTE_I,      // pulse, first address byte done
	input  wire        ADDR2_BYTE_I,     // pulse, second 10-bit byte done
	input  wire        DATA_BYTE_I,      // pulse, slave data byte done
	input  wire [9:0]  RX_ADDR_I,        // incoming address bits
	input  wire        RX_RW_I,          // read bit of address byte
	input  wire [7:0]  RX_SHIFT_I,       // receive shift contents
	input  wire        RX_BYTE_DONE_I,   // pulse, shift holds full byte
	input  wire        TX_DONE_I,        // pulse, transmit data done
	input  wire        BUSY_I,           // engine busy level
	output reg  [7:0]  TX_DATA_O,        // transmit holding register
	output reg         TX_LOAD_O,        // pulse, new transmit byte
	output reg         ADDR_MATCH_O,     // address matched, level
	output reg         RX_IRQ_O,         // pulse on receive load
	output reg         IRQ_O             // level interrupt
);
`include "isam_map.vh"
	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire        setup  = PSEL_I & ~PENABLE_I;
	wire        access = PSEL_I & PENABLE_I & PREADY_O;
	wire        wr     = access & PWRITE_I;
	wire        rd     = access & ~PWRITE_I;
	// one wait-free access cycle: ready is raised in the cycle after setup
	// only, so every transfer takes exactly two clock cycles on the bus;
	// writes land at the access edge, where psel, penable and ready are high
	// exact compare of a byte address against one register offset
	function hit;
		input [11:0] a;
		input [11:0] o;
		begin
			hit = (a == o);
		end
	endfunction
	// an offset outside the table answers with an error and no effect
	function mapped;
		input [11:0] a;
		begin
			mapped = hit(a, `ISAM_OFF_STAT) | hit(a, `ISAM_OFF_MASK) | hit(a, `ISAM_OFF_CTRL) |
				hit(a, `ISAM_OFF_ADDR) | hit(a, `ISAM_OFF_TXD) | hit(a, `ISAM_OFF_RXD) |
				hit(a, `ISAM_OFF_IRQ_STAT) | hit(a, `ISAM_OFF_IRQ_EN) | hit(a, `ISAM_OFF_IRQ_CLR);
		end
	endfunction
	////////////////////////////////////////////////////////////////////////
	// storage
	// one flop per status flag, so each is set and cleared on its own
	reg         ack_result_flag_ff;
	reg         master_tx_busy_flag_ff;
	reg         bus_collision_flag_ff;
	reg         general_call_seen_ff;
	reg         ten_bit_match_flag_ff;
	reg         tx_write_collision_ff;
	reg         rx_overflow_flag_ff;
	reg         data_not_addr_ff;
	reg         stop_seen_ff;
	reg         start_seen_ff;
	reg         slave_read_ff;
	reg         rx_buffer_full_ff;
	reg         tx_buffer_full_ff;
	reg  [9:0]  address_bit_mask_ff;
	reg  [1:0]  ctrl_ff;
	reg  [9:0]  own_addr_ff;
	reg  [7:0]  rx_holding_register_ff;
	reg  [3:0]  irq_stat_ff;
	reg  [3:0]  irq_en_ff;
	// event qualifiers, decoded once and shared by the flag processes
	wire        match;
	wire        gc_hit;
	wire [15:0] stat_word;
	wire [3:0]  irq_evt;
	wire [3:0]  irq_clr;
	wire        txd_wr = wr & hit(PADDR_I, `ISAM_OFF_TXD);
	wire        rxd_rd = rd & hit(PADDR_I, `ISAM_OFF_RXD);
	wire        stat_wr = wr & hit(PADDR_I, `ISAM_OFF_STAT);
	wire        address_width_select = ctrl_ff[`ISAM_CTRL_TEN];
	// a write while the engine runs would corrupt the shifting byte;
	// a full holding register refuses too, so no byte is overwritten
	wire        tx_reject = txd_wr & (BUSY_I | tx_buffer_full_ff);
	// a byte arriving into a full buffer is dropped, never merged
	wire        rx_load = RX_BYTE_DONE_I & ~rx_buffer_full_ff;
	////////////////////////////////////////////////////////////////////////
	// address comparator
	// mask and width select meet inside the comparator; the general call
	// bypasses the mask and needs its enable bit set
	isam_addr_match u_match (
		.own_addr_i (own_addr_ff),
		.rx_addr_i  (RX_ADDR_I),
		.mask_i     (address_bit_mask_ff),
		.ten_bit_i  (address_width_select),
		.match_o    (match)
	);
	// general call: an all-zero address byte, honoured only when enabled
	assign gc_hit = ctrl_ff[`ISAM_CTRL_GCEN] & (RX_ADDR_I == `ISAM_GC_ADDR);
	////////////////////////////////////////////////////////////////////////
	// master transmit flags
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ack_result_flag_ff     <= 1'b0;
			master_tx_busy_flag_ff <= 1'b0;
		end else begin
			// the ack level is only meaningful in the cycle of the slot end pulse;
			// busy covers the eight data bits and the ack slot that follows
			if (ACK_SLOT_END_I)
				ack_result_flag_ff <= ACK_NACK_I;
			// a new byte starting wins over the previous ack end
			if (MTX_START_I)
				master_tx_busy_flag_ff <= 1'b1;
			else if (ACK_SLOT_END_I)
				master_tx_busy_flag_ff <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// sticky error flags, software clears by writing zero, set wins
	// a clear written in the same cycle as a fresh event is lost, so an
	// event is never missed by software polling the status word
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bus_collision_flag_ff <= 1'b0;
			tx_write_collision_ff <= 1'b0;
			rx_overflow_flag_ff   <= 1'b0;
		end else begin
			if (COLLISION_I)
				bus_collision_flag_ff <= 1'b1;
			else if (stat_wr && !PWDATA_I[`ISAM_B_COLL])
				bus_collision_flag_ff <= 1'b0;
			if (tx_reject)
				tx_write_collision_ff <= 1'b1;
			else if (stat_wr && !PWDATA_I[`ISAM_B_WCOL])
				tx_write_collision_ff <= 1'b0;
			if (RX_BYTE_DONE_I && rx_buffer_full_ff)
				rx_overflow_flag_ff <= 1'b1;
			else if (stat_wr && !PWDATA_I[`ISAM_B_OV])
				rx_overflow_flag_ff <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// slave address flags and bus conditions
	// stop and start both end an addressed transfer, so the match level
	// drops on either one
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			general_call_seen_ff  <= 1'b0;
			ten_bit_match_flag_ff <= 1'b0;
			data_not_addr_ff      <= 1'b0;
			slave_read_ff         <= 1'b0;
			stop_seen_ff          <= 1'b0;
			start_seen_ff         <= 1'b0;
			ADDR_MATCH_O          <= 1'b0;
		end else begin
			if (ADDR_BYTE_I && gc_hit)
				general_call_seen_ff <= 1'b1;
			else if (STOP_DET_I)
				general_call_seen_ff <= 1'b0;
			if (ADDR2_BYTE_I && address_width_select && match)
				ten_bit_match_flag_ff <= 1'b1;
			else if (STOP_DET_I)
				ten_bit_match_flag_ff <= 1'b0;
			// in ten-bit mode the match is final only on the second byte
			if ((ADDR_BYTE_I && !address_width_select && match) ||
				(ADDR2_BYTE_I && address_width_select && match) ||
				(ADDR_BYTE_I && gc_hit)) begin
				data_not_addr_ff <= 1'b0;
				ADDR_MATCH_O     <= 1'b1;
			end else if (DATA_BYTE_I) begin
				data_not_addr_ff <= 1'b1;
			end
			if (STOP_DET_I || START_DET_I)
				ADDR_MATCH_O <= 1'b0;
			// direction is taken from every first address byte, matched or not; the second 10-bit byte leaves it
			if (ADDR_BYTE_I)
				slave_read_ff <= RX_RW_I;
			// stop beats start when both are reported in one cycle
			if (STOP_DET_I) begin
				stop_seen_ff  <= 1'b1;
				start_seen_ff <= 1'b0;
			end else if (START_DET_I) begin
				stop_seen_ff  <= 1'b0;
				start_seen_ff <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// buffers: receive holding and transmit holding
	// the receive holding register is not cleared by a read: software
	// must watch the full flag, not the data, to know a byte is new
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rx_buffer_full_ff      <= 1'b0;
			rx_holding_register_ff <= 8'h00;
			tx_buffer_full_ff      <= 1'b0;
			TX_DATA_O              <= 8'h00;
			TX_LOAD_O              <= 1'b0;
			RX_IRQ_O               <= 1'b0;
		end else begin
			// overflow keeps the old byte, the new one is dropped
			if (rx_load) begin
				rx_holding_register_ff <= RX_SHIFT_I;
				rx_buffer_full_ff      <= 1'b1;
			end else if (rxd_rd) begin
				rx_buffer_full_ff <= 1'b0;
			end
			RX_IRQ_O  <= rx_load;
			// one-cycle strobe, so the engine takes each byte once
			TX_LOAD_O <= txd_wr & ~tx_reject;
			if (txd_wr && !tx_reject) begin
				TX_DATA_O         <= PWDATA_I[7:0];
				tx_buffer_full_ff <= 1'b1;
			end else if (TX_DONE_I) begin
				tx_buffer_full_ff <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// configuration registers
	// only the low bits of each word are stored; the rest read back as zero
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			address_bit_mask_ff <= 10'h000;
			ctrl_ff             <= 2'b00;
			own_addr_ff         <= 10'h000;
			irq_en_ff           <= 4'h0;
		end else if (wr) begin
			if (hit(PADDR_I, `ISAM_OFF_MASK))
				address_bit_mask_ff <= PWDATA_I[`ISAM_MASK_W-1:0];
			if (hit(PADDR_I, `ISAM_OFF_CTRL))
				ctrl_ff <= PWDATA_I[1:0];
			if (hit(PADDR_I, `ISAM_OFF_ADDR))
				own_addr_ff <= PWDATA_I[9:0];
			if (hit(PADDR_I, `ISAM_OFF_IRQ_EN))
				irq_en_ff <= PWDATA_I[`ISAM_IRQ_W-1:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// interrupt status, set wins over clear
	assign irq_evt[`ISAM_IRQ_RX]   = rx_load;
	assign irq_evt[`ISAM_IRQ_COLL] = COLLISION_I;
	assign irq_evt[`ISAM_IRQ_WCOL] = tx_reject;
	assign irq_evt[`ISAM_IRQ_OV]   = RX_BYTE_DONE_I & rx_buffer_full_ff;
	// clear mask from a write to the clear register, zero otherwise
	assign irq_clr = (wr & hit(PADDR_I, `ISAM_OFF_IRQ_CLR)) ? PWDATA_I[`ISAM_IRQ_W-1:0] : 4'h0;
	// one flop per interrupt source; a clear and a fresh event together leave it set
	genvar gi;
	generate
		for (gi = 0; gi < `ISAM_IRQ_W; gi = gi + 1) begin : g_irq
			always @(posedge CLK_I or negedge RST_B_I) begin
				if (!RST_B_I)
					irq_stat_ff[gi] <= 1'b0;
				else if (irq_evt[gi])
					irq_stat_ff[gi] <= 1'b1;
				else if (irq_clr[gi])
					irq_stat_ff[gi] <= 1'b0;
			end
		end
	endgenerate
	// registered, so it trails the status bit by one cycle
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(irq_stat_ff & irq_en_ff);
	end
	////////////////////////////////////////////////////////////////////////
	// status word, unimplemented bits zero
	// bit order follows the status layout, most significant first
	assign stat_word = {ack_result_flag_ff, master_tx_busy_flag_ff, 3'b000,
		bus_collision_flag_ff, general_call_seen_ff, ten_bit_match_flag_ff,
		tx_write_collision_ff, rx_overflow_flag_ff, data_not_addr_ff, stop_seen_ff,
		start_seen_ff, slave_read_ff, rx_buffer_full_ff, tx_buffer_full_ff};
	////////////////////////////////////////////////////////////////////////
	// apb answer: ready one cycle after setup, data registered
	// read data is captured at setup so the value cannot change while the
	// access cycle is open; a receive read clears the full flag only at the
	// access edge, after its byte has already been captured
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= `ISAM_ZERO32;
			PSLVERR_O <= 1'b0;
		end else begin
			// error answer only for offsets outside the map; writes there change nothing
			PREADY_O  <= setup;
			PSLVERR_O <= setup & ~mapped(PADDR_I);
			if (setup && !PWRITE_I) begin
				PRDATA_O <= `ISAM_ZERO32;
				if (hit(PADDR_I, `ISAM_OFF_STAT))
					PRDATA_O <= {`ISAM_ZERO16, stat_word};
				if (hit(PADDR_I, `ISAM_OFF_MASK))
					PRDATA_O <= {22'h000000, address_bit_mask_ff};
				if (hit(PADDR_I, `ISAM_OFF_CTRL))
					PRDATA_O <= {30'h00000000, ctrl_ff};
				if (hit(PADDR_I, `ISAM_OFF_ADDR))
					PRDATA_O <= {22'h000000, own_addr_ff};
				if (hit(PADDR_I, `ISAM_OFF_RXD))
					PRDATA_O <= {24'h000000, rx_holding_register_ff};
				if (hit(PADDR_I, `ISAM_OFF_TXD))
					PRDATA_O <= {24'h000000, TX_DATA_O};
				if (hit(PADDR_I, `ISAM_OFF_IRQ_STAT))
					PRDATA_O <= {28'h0000000, irq_stat_ff};
				if (hit(PADDR_I, `ISAM_OFF_IRQ_EN))
					PRDATA_O <= {28'h0000000, irq_en_ff};
			end else if (!PSEL_I) begin
				PRDATA_O <= `ISAM_ZERO32;
			end
		end
	end
endmodule // isam_top

// File: testbench/isam_top_chk.sv
// port-level assertion checker for the status flags and address mask block
`timescale 1ns/1ps
`include "isam_map.vh"
module isam_top_chk (
	input wire        CLK_I,          // module clock
	input wire        RST_B_I,        // async reset, active low
	input wire        PSEL_I,         // apb select
	input wire        PENABLE_I,      // apb access phase
	input wire        PWRITE_I,       // apb direction
	input wire [11:0] PADDR_I,        // apb byte address
	input wire [31:0] PRDATA_O,       // apb read data
	input wire        PREADY_O,       // apb ready
	input wire        STOP_DET_I,     // stop pulse
	input wire        RX_BYTE_DONE_I, // full byte pulse
	input wire        BUSY_I,         // engine busy
	input wire        TX_LOAD_O,      // transmit load pulse
	input wire        ADDR_MATCH_O,   // address matched
	input wire        RX_IRQ_O        // receive load pulse
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////
	// completed reads and transmit writes, judged at the ready edge
	wire rd_ok = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
	wire tx_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && (PADDR_I == `ISAM_OFF_TXD);
	property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing after setup");
	property p_rdy1; PREADY_O |=> !PREADY_O; endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
	property p_stat_rz; rd_ok && PADDR_I == `ISAM_OFF_STAT |-> PRDATA_O[31:16] == 0 && PRDATA_O[13:11] == 0; endproperty
	a_stat_rz: assert property (p_stat_rz) else $error("status reserved bits not zero");
	property p_mask_rz; rd_ok && PADDR_I == `ISAM_OFF_MASK |-> PRDATA_O[31:10] == 0; endproperty
	a_mask_rz: assert property (p_mask_rz) else $error("mask reserved bits not zero");
	property p_txrej; tx_wr && BUSY_I |=> !TX_LOAD_O [*2]; endproperty
	a_txrej: assert property (p_txrej) else $error("transmit write accepted while busy");
	property p_txload; TX_LOAD_O |-> $past(tx_wr) || $past(tx_wr, 2); endproperty
	a_txload: assert property (p_txload) else $error("transmit load without a write");
	property p_rxirq; RX_IRQ_O |-> $past(RX_BYTE_DONE_I) || $past(RX_BYTE_DONE_I, 2); endproperty
	a_rxirq: assert property (p_rxirq) else $error("receive pulse without a byte");
	property p_stop; STOP_DET_I |=> !ADDR_MATCH_O; endproperty
	a_stop: assert property (p_stop) else $error("match held past stop");
endmodule // isam_top_chk
bind isam_top isam_top_chk i_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .STOP_DET_I(STOP_DET_I),
	.RX_BYTE_DONE_I(RX_BYTE_DONE_I), .BUSY_I(BUSY_I), .TX_LOAD_O(TX_LOAD_O), .ADDR_MATCH_O(ADDR_MATCH_O),
	.RX_IRQ_O(RX_IRQ_O));

// File: testbench/isam_bus_model.sv
// far-side model: other bus parties, seen as decoded one-cycle events
`timescale 1ns/1ps
module isam_bus_model (
	input  wire       clk_i,  // module clock
	output reg  [9:0] ev_o,   // one-hot event pulses
	output reg  [9:0] addr_o, // address or byte bits
	output reg        bit_o,  // read bit or nack level
	output reg        busy_o  // engine busy level
);
	// quiet bus at time zero
	initial begin
		ev_o = 10'h000;
		addr_o = 10'h000;
		bit_o = 1'b0;
		busy_o = 1'b0;
	end
	// released lines flip so stale data never looks valid
	task ev(input integer k, input [9:0] a, input b);
		begin
			@(posedge clk_i);
			ev_o <= 10'h001 << k;
			addr_o <= a;
			bit_o <= b;
			@(posedge clk_i);
			ev_o <= 10'h000;
			addr_o <= ~a;
			bit_o <= ~b;
		end
	endtask
	// engine busy level
	task busy(input b);
		begin
			@(posedge clk_i);
			busy_o <= b;
		end
	endtask
endmodule // isam_bus_model

// File: testbench/tb_top.sv
// self-checking bench for the status flags and address mask block
`timescale 1ns/1ps
module tb_top;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg         psel = 1'b0;
	reg         pen = 1'b0;
	reg         pwr = 1'b0;
	reg  [11:0] padr = 12'h000;
	reg  [31:0] pwd = 32'h0;
	reg  [31:0] q;
	reg         se;
	wire [31:0] prd;
	wire        prdy, perr, b, bsy, am, irq, txl, rxi;
	wire [9:0]  ev, a;
	wire [7:0]  txd;
	integer     err_count = 0;
	integer     n_checks = 0;
	integer     n_txl = 0;
	integer     n_rxi = 0;
	isam_bus_model i_bus (.clk_i(clk), .ev_o(ev), .addr_o(a), .bit_o(b), .busy_o(bsy));
	isam_top i_dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.ACK_SLOT_END_I(ev[0]), .ACK_NACK_I(b), .MTX_START_I(ev[1]), .COLLISION_I(ev[2]),
		.START_DET_I(ev[3]), .STOP_DET_I(ev[4]), .ADDR_BYTE_I(ev[5]), .ADDR2_BYTE_I(ev[6]),
		.DATA_BYTE_I(ev[7]), .RX_ADDR_I(a), .RX_RW_I(b), .RX_SHIFT_I(a[7:0]), .RX_BYTE_DONE_I(ev[8]),
		.TX_DONE_I(ev[9]), .BUSY_I(bsy), .TX_DATA_O(txd), .TX_LOAD_O(txl), .ADDR_MATCH_O(am),
		.RX_IRQ_O(rxi), .IRQ_O(irq));
	////////////////////////////////////////
	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end
	// strobe counters: a stuck or doubled pulse shows up as a wrong count
	always @(posedge clk) begin
		if (txl === 1'b1)
			n_txl <= n_txl + 1;
		if (rxi === 1'b1)
			n_rxi <= n_rxi + 1;
	end
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("Error at %0t: saw %h, expected %h", $time, g, e);
			end
		end
	endtask
	// request held until ready is sampled; a hang is left to the watchdog
	task apb(input w, input [11:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwr <= w;
			padr <= ad;
			pwd <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (prdy !== 1'b1) @(posedge clk);
			q = prd;
			se = perr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task wr(input [11:0] ad, input [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task rd(input [11:0] ad, input [31:0] m, input [31:0] e);
		begin
			apb(1'b0, ad, 32'h0);
			chk(q & m, e);
		end
	endtask
	task finish_test;
		begin
			if (err_count == 0 && n_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// one slave address byte after a start, then flags and match
	task m1(input [9:0] m, input [9:0] ad, input r, input e);
		begin
			wr(12'h004, {22'h0, m});
			i_bus.ev(3, 10'h0, 1'b0);
			i_bus.ev(5, ad, r);
			rd(12'h000, e ? 32'h24 : 32'h0, {29'h0, r & e, 2'b00});
			chk(am, e);
		end
	endtask
	////////////////////////////////////////
	// scenarios run back to back after reset
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, read-only bits, unmapped place
		rd(12'h000, 32'hffffffff, 32'h0);
		wr(12'h000, 32'hffffffff);
		rd(12'h000, 32'hffffffff, 32'h0);
		wr(12'h004, 32'hffffffff);
		rd(12'h004, 32'hffffffff, 32'h3ff);
		wr(12'h0fc, 32'h1);
		chk(se, 1);
		// master byte, nack then ack
		i_bus.ev(1, 10'h0, 1'b0);
		rd(12'h000, 32'hc000, 32'h4000);
		i_bus.ev(0, 10'h0, 1'b1);
		rd(12'h000, 32'hc000, 32'h8000);
		i_bus.ev(0, 10'h0, 1'b0);
		rd(12'h000, 32'hc000, 32'h0);
		// collision: masked, enabled, cleared
		i_bus.ev(2, 10'h0, 1'b0);
		wr(12'h000, 32'hffff);
		rd(12'h000, 32'h400, 32'h400);
		chk(irq, 0);
		wr(12'h01c, 32'h2);
		rd(12'h018, 32'hf, 32'h2);
		chk(irq, 1);
		wr(12'h000, 32'h0);
		wr(12'h020, 32'h2);
		rd(12'h000, 32'h400, 32'h0);
		chk(irq, 0);
		// start, general call, stop
		wr(12'h008, 32'h2);
		i_bus.ev(3, 10'h0, 1'b0);
		rd(12'h000, 32'h18, 32'h8);
		i_bus.ev(5, 10'h0, 1'b0);
		rd(12'h000, 32'h218, 32'h208);
		i_bus.ev(4, 10'h0, 1'b0);
		rd(12'h000, 32'h218, 32'h10);
		// seven-bit masked compare, then a data byte
		wr(12'h008, 32'h0);
		wr(12'h00c, 32'h052);
		m1(10'h000, 10'h052, 1'b1, 1'b1);
		m1(10'h000, 10'h3d2, 1'b0, 1'b1);
		m1(10'h000, 10'h053, 1'b0, 1'b0);
		m1(10'h001, 10'h053, 1'b0, 1'b1);
		m1(10'h040, 10'h012, 1'b1, 1'b1);
		i_bus.ev(7, 10'h0, 1'b0);
		rd(12'h000, 32'h20, 32'h20);
		// ten-bit compare on the second byte
		wr(12'h008, 32'h1);
		wr(12'h00c, 32'h2a5);
		wr(12'h004, 32'h0);
		i_bus.ev(6, 10'h0a5, 1'b0);
		rd(12'h000, 32'h100, 32'h0);
		i_bus.ev(6, 10'h2a5, 1'b0);
		rd(12'h000, 32'h100, 32'h100);
		i_bus.ev(4, 10'h0, 1'b0);
		rd(12'h000, 32'h100, 32'h0);
		// receive load, read, overflow keeps the old byte
		i_bus.ev(8, 10'h03c, 1'b0);
		rd(12'h000, 32'h42, 32'h2);
		rd(12'h014, 32'hff, 32'h3c);
		rd(12'h000, 32'h2, 32'h0);
		i_bus.ev(8, 10'h011, 1'b0);
		i_bus.ev(8, 10'h022, 1'b0);
		rd(12'h000, 32'h42, 32'h42);
		rd(12'h014, 32'hff, 32'h11);
		chk(n_rxi, 32'h2);
		wr(12'h000, 32'h0);
		rd(12'h000, 32'h42, 32'h0);
		// transmit: accept, refuse while full and while busy
		wr(12'h010, 32'ha5);
		rd(12'h000, 32'h81, 32'h1);
		wr(12'h010, 32'h5a);
		rd(12'h000, 32'h81, 32'h81);
		i_bus.ev(9, 10'h0, 1'b0);
		rd(12'h000, 32'h1, 32'h0);
		wr(12'h000, 32'h0);
		i_bus.busy(1'b1);
		wr(12'h010, 32'h33);
		rd(12'h000, 32'h81, 32'h80);
		chk(txd, 32'ha5);
		chk(n_txl, 32'h1);
		i_bus.busy(1'b0);
		finish_test;
	end
	// watchdog against a hung handshake
	initial begin
		#20000;
		err_count = err_count + 1;
		finish_test;
	end
endmodule // tb_top
